// [src/qtc_pkg.sv]
// Purpose: Shared constants and types for the quad timer/counter block
// Assumes: One system clock (mclk), 20 MHz
// Notes:   Mode and divider encodings used by the top module ports
`default_nettype none
package qtc_pkg;
    // Prescaler divide ratios
    localparam logic [5:0] QTC_DIV12     = 6'h0c;
    localparam logic [5:0] QTC_DIV4      = 6'h04;
    localparam logic [5:0] QTC_DIV48     = 6'h30;
    localparam logic [5:0] QTC_EXT_DIV   = 6'h08;
    // Divider choice encodings
    localparam logic [1:0] QTC_SCA_12    = 2'h0;
    localparam logic [1:0] QTC_SCA_4     = 2'h1;
    localparam logic [1:0] QTC_SCA_48    = 2'h2;
    localparam logic [1:0] QTC_SCA_EXT   = 2'h3;
    // Reset values
    localparam logic [15:0] QTC_CNT_RST  = 16'h0000;
    localparam logic [5:0]  QTC_PRE_RST  = 6'h00;

    // Timer 0/1 modes
    typedef enum logic [1:0] {
        QTC_M13    = 2'h0,
        QTC_M16    = 2'h1,
        QTC_M8AR   = 2'h2,
        QTC_MSPLIT = 2'h3
    } qtc_mode01_e;

    // Per-timer control group for timers 0 and 1
    typedef struct packed {
        logic        run;
        logic        counter_mode;
        logic        clock_choice;
        qtc_mode01_e mode;
    } qtc_t01_ctl_s;

    // Per-timer control group for timers 2 and 3
    typedef struct packed {
        logic run;
        logic split;
        logic alt_clock_choice;
        logic low_clock_choice;
        logic high_clock_choice;
    } qtc_t23_ctl_s;
endpackage : qtc_pkg
`default_nettype wire

// [src/qtc_top.sv]
// Purpose: Four counter/timers with clock selection and event pins
// Assumes: Event pins and external clock are asynchronous to mclk
// Notes:   Overflow flags are one-cycle pulses; software side keeps flags
`default_nettype none
module qtc_top (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset,
    // Clocking control
    input  wire logic [1:0]            timer01_divider_choice,
    input  wire qtc_pkg::qtc_t01_ctl_s timer0_ctl,
    input  wire qtc_pkg::qtc_t01_ctl_s timer1_ctl,
    input  wire qtc_pkg::qtc_t23_ctl_s timer2_control,
    input  wire qtc_pkg::qtc_t23_ctl_s timer3_control,
    // Reload values for timers 0/1 (low byte) and 2/3
    input  wire logic [7:0]            timer0_reload,
    input  wire logic [7:0]            timer1_reload,
    input  wire logic [15:0]           timer2_reload,
    input  wire logic [15:0]           timer3_reload,
    // External pins
    input  wire logic                  timer0_event_pin,
    input  wire logic                  timer1_event_pin,
    input  wire logic                  ext_clock,
    // Counts and overflow requests
    output logic [15:0]                timer0_count,
    output logic [15:0]                timer1_count,
    output logic [15:0]                timer2_count,
    output logic [15:0]                timer3_count,
    output logic [7:0]                 overflow_irq
);
    import qtc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers, falling-edge detect on event pins, rising-edge detect on ext clock
    logic [2:0] sync0;
    logic [2:0] sync1;
    logic [2:0] syncx;
    logic [2:0] next_sync0;
    logic [2:0] next_sync1;
    logic [2:0] next_syncx;
    logic       ev0;
    logic       ev1;
    logic       ext_rise;

    always_comb begin
        next_sync0 = {sync0[1:0], timer0_event_pin};
        next_sync1 = {sync1[1:0], timer1_event_pin};
        next_syncx = {syncx[1:0], ext_clock};
    end
    // Stage [2] is the previous synced level; [0] is read only by [1]
    assign ev0      = sync0[2] & ~sync0[1];
    assign ev1      = sync1[2] & ~sync1[1];
    assign ext_rise = ~syncx[2] & syncx[1];

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sync0 <= 3'h7;
            sync1 <= 3'h7;
            syncx <= 3'h0;
        end else begin
            sync0 <= next_sync0;
            sync1 <= next_sync1;
            syncx <= next_syncx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescalers: /4, /12, /48 and external/8 ticks
    logic [5:0] pre4;
    logic [5:0] pre12;
    logic [5:0] pre48;
    logic [5:0] prex;
    logic [5:0] next_pre4;
    logic [5:0] next_pre12;
    logic [5:0] next_pre48;
    logic [5:0] next_prex;
    logic       tick4;
    logic       tick12;
    logic       tick48;
    logic       tickx;
    logic       tick01;

    assign tick4  = (pre4 == QTC_DIV4 - 6'h01);
    assign tick12 = (pre12 == QTC_DIV12 - 6'h01);
    assign tick48 = (pre48 == QTC_DIV48 - 6'h01);
    assign tickx  = ext_rise && (prex == QTC_EXT_DIV - 6'h01);

    always_comb begin
        next_pre4  = tick4  ? QTC_PRE_RST : pre4 + 6'h01;
        next_pre12 = tick12 ? QTC_PRE_RST : pre12 + 6'h01;
        next_pre48 = tick48 ? QTC_PRE_RST : pre48 + 6'h01;
        next_prex  = prex;
        if (ext_rise)
            next_prex = tickx ? QTC_PRE_RST : prex + 6'h01;
        // Shared divider selection for timers 0/1
        unique case (timer01_divider_choice)
            QTC_SCA_12:  tick01 = tick12;
            QTC_SCA_4:   tick01 = tick4;
            QTC_SCA_48:  tick01 = tick48;
            QTC_SCA_EXT: tick01 = tickx;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pre4  <= QTC_PRE_RST;
            pre12 <= QTC_PRE_RST;
            pre48 <= QTC_PRE_RST;
            prex  <= QTC_PRE_RST;
        end else begin
            pre4  <= next_pre4;
            pre12 <= next_pre12;
            pre48 <= next_pre48;
            prex  <= next_prex;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Increment enables per timer
    logic inc0;
    logic inc1;
    logic inc0h;
    logic alt2;
    logic alt3;
    logic inc2l;
    logic inc2h;
    logic inc3l;
    logic inc3h;

    always_comb begin
        // Counter mode overrides clock choice
        inc0  = timer0_ctl.counter_mode ? ev0
              : (timer0_ctl.clock_choice ? 1'b1 : tick01);
        inc1  = timer1_ctl.counter_mode ? ev1
              : (timer1_ctl.clock_choice ? 1'b1 : tick01);
        // Split timer 0 high half is a timer on timer 0 clock
        inc0h = timer0_ctl.clock_choice ? 1'b1 : tick01;
        alt2  = timer2_control.alt_clock_choice ? tickx : tick12;
        alt3  = timer3_control.alt_clock_choice ? tickx : tick12;
        inc2l = timer2_control.low_clock_choice ? 1'b1 : alt2;
        inc2h = timer2_control.high_clock_choice ? 1'b1 : alt2;
        inc3l = timer3_control.low_clock_choice ? 1'b1 : alt3;
        inc3h = timer3_control.high_clock_choice ? 1'b1 : alt3;
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer 0 to 3 count logic
    logic [15:0] next_cnt0;
    logic [15:0] next_cnt1;
    logic [15:0] next_cnt2;
    logic [15:0] next_cnt3;
    logic [7:0]  next_irq;

    always_comb begin
        next_cnt0 = timer0_count;
        next_cnt1 = timer1_count;
        next_cnt2 = timer2_count;
        next_cnt3 = timer3_count;
        next_irq  = 8'h00;
        // Timer 0
        if (timer0_ctl.run && inc0) begin
            unique case (timer0_ctl.mode)
                QTC_M13: begin
                    // Low 5 bits then high 8 bits form 13 bits
                    next_cnt0[4:0] = timer0_count[4:0] + 5'h01;
                    next_cnt0[7:5] = 3'h0;
                    if (&timer0_count[4:0]) begin
                        next_cnt0[15:8] = timer0_count[15:8] + 8'h01;
                        next_irq[0]     = &timer0_count[15:8];
                    end
                end
                QTC_M16: begin
                    next_cnt0   = timer0_count + 16'h0001;
                    next_irq[0] = &timer0_count;
                end
                QTC_M8AR: begin
                    next_cnt0[7:0] = (&timer0_count[7:0]) ? timer0_reload
                                   : timer0_count[7:0] + 8'h01;
                    next_irq[0]    = &timer0_count[7:0];
                end
                QTC_MSPLIT: begin
                    next_cnt0[7:0] = timer0_count[7:0] + 8'h01;
                    next_irq[0]    = &timer0_count[7:0];
                end
            endcase
        end
        // Split timer 0 high half, its overflow on bit 1
        if (timer0_ctl.mode == QTC_MSPLIT && timer1_ctl.run && inc0h) begin
            next_cnt0[15:8] = timer0_count[15:8] + 8'h01;
            next_irq[1]     = &timer0_count[15:8];
        end
        // Timer 1; split mode is not offered and holds it
        if (timer1_ctl.run && inc1) begin
            unique case (timer1_ctl.mode)
                QTC_M13: begin
                    next_cnt1[4:0] = timer1_count[4:0] + 5'h01;
                    next_cnt1[7:5] = 3'h0;
                    if (&timer1_count[4:0]) begin
                        next_cnt1[15:8] = timer1_count[15:8] + 8'h01;
                        next_irq[2]     = &timer1_count[15:8];
                    end
                end
                QTC_M16: begin
                    next_cnt1   = timer1_count + 16'h0001;
                    next_irq[2] = &timer1_count;
                end
                QTC_M8AR: begin
                    next_cnt1[7:0] = (&timer1_count[7:0]) ? timer1_reload
                                   : timer1_count[7:0] + 8'h01;
                    next_irq[2]    = &timer1_count[7:0];
                end
                QTC_MSPLIT: begin
                    next_cnt1 = timer1_count;
                end
            endcase
        end
        // Timer 2: 16-bit reload or split halves
        if (timer2_control.run) begin
            if (!timer2_control.split) begin
                if (inc2l) begin
                    next_cnt2   = (&timer2_count) ? timer2_reload
                                : timer2_count + 16'h0001;
                    next_irq[4] = &timer2_count;
                end
            end else begin
                if (inc2l) begin
                    next_cnt2[7:0] = (&timer2_count[7:0]) ? timer2_reload[7:0]
                                   : timer2_count[7:0] + 8'h01;
                    next_irq[4]    = &timer2_count[7:0];
                end
                if (inc2h) begin
                    next_cnt2[15:8] = (&timer2_count[15:8])
                                    ? timer2_reload[15:8]
                                    : timer2_count[15:8] + 8'h01;
                    next_irq[5]     = &timer2_count[15:8];
                end
            end
        end
        // Timer 3: same structure as timer 2
        if (timer3_control.run) begin
            if (!timer3_control.split) begin
                if (inc3l) begin
                    next_cnt3   = (&timer3_count) ? timer3_reload
                                : timer3_count + 16'h0001;
                    next_irq[6] = &timer3_count;
                end
            end else begin
                if (inc3l) begin
                    next_cnt3[7:0] = (&timer3_count[7:0]) ? timer3_reload[7:0]
                                   : timer3_count[7:0] + 8'h01;
                    next_irq[6]    = &timer3_count[7:0];
                end
                if (inc3h) begin
                    next_cnt3[15:8] = (&timer3_count[15:8])
                                    ? timer3_reload[15:8]
                                    : timer3_count[15:8] + 8'h01;
                    next_irq[7]     = &timer3_count[15:8];
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            timer0_count <= QTC_CNT_RST;
            timer1_count <= QTC_CNT_RST;
            timer2_count <= QTC_CNT_RST;
            timer3_count <= QTC_CNT_RST;
            overflow_irq <= 8'h00;
        end else begin
            timer0_count <= next_cnt0;
            timer1_count <= next_cnt1;
            timer2_count <= next_cnt2;
            timer3_count <= next_cnt3;
            overflow_irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_fall0;
        sync0[2] && !sync0[1];
    endsequence

    property p_event_count;
        @(posedge mclk) disable iff (reset)
        (s_fall0 and (timer0_ctl.run && timer0_ctl.counter_mode
         && timer0_ctl.mode == QTC_M16)) |=>
            timer0_count == $past(timer0_count) + 16'h0001;
    endproperty
    a_event_count: assert property (p_event_count)
        else $error("Timer 0 missed an event increment");

    property p_single_pulse;
        @(posedge mclk) disable iff (reset)
        ev0 |=> !ev0;
    endproperty
    a_single_pulse: assert property (p_single_pulse)
        else $error("Edge pulse lasted more than one cycle");

    property p_no_count_no_event;
        @(posedge mclk) disable iff (reset)
        (timer1_ctl.counter_mode && !ev1) |=>
            timer1_count == $past(timer1_count);
    endproperty
    a_no_count_no_event: assert property (p_no_count_no_event)
        else $error("Timer 1 counted with no event in counter mode");

    property p_div4;
        @(posedge mclk) disable iff (reset)
        tick4 |=> !tick4 [*3] ##1 tick4;
    endproperty
    a_div4: assert property (p_div4)
        else $error("Divide by 4 tick spacing wrong");

    property p_div12;
        @(posedge mclk) disable iff (reset)
        tick12 |=> !tick12 ##11 tick12;
    endproperty
    a_div12: assert property (p_div12)
        else $error("Divide by 12 tick spacing wrong");

    property p_sysclk_t2;
        @(posedge mclk) disable iff (reset)
        (timer2_control.run && !timer2_control.split
         && timer2_control.low_clock_choice && !(&timer2_count)) |=>
            timer2_count == $past(timer2_count) + 16'h0001;
    endproperty
    a_sysclk_t2: assert property (p_sysclk_t2)
        else $error("Timer 2 failed to count on system clock");

    property p_reload_t3;
        @(posedge mclk) disable iff (reset)
        (timer3_control.run && !timer3_control.split && inc3l
         && (&timer3_count)) |=>
            timer3_count == $past(timer3_reload) && overflow_irq[6];
    endproperty
    a_reload_t3: assert property (p_reload_t3)
        else $error("Timer 3 reload or overflow request missing");

    property p_ovf16_t0;
        @(posedge mclk) disable iff (reset)
        (timer0_ctl.run && timer0_ctl.mode == QTC_M16 && inc0
         && (&timer0_count)) |=> overflow_irq[0] && timer0_count == 16'h0000;
    endproperty
    a_ovf16_t0: assert property (p_ovf16_t0)
        else $error("Timer 0 overflow request missing");

    property p_m13_low;
        @(posedge mclk) disable iff (reset)
        (timer1_ctl.run && timer1_ctl.mode == QTC_M13 && inc1) |=>
            timer1_count[7:5] == 3'h0;
    endproperty
    a_m13_low: assert property (p_m13_low)
        else $error("Timer 1 13-bit mode used more than 5 low bits");
endmodule : qtc_top
`default_nettype wire

// [testbench/qtc_pins.sv]
// Purpose: Outside circuitry driving the event pins and external clock
// Assumes: Event pins idle high; external clock stands low between bursts
// Notes:   Every level is held for at least two mclk cycles
`default_nettype none
module qtc_pins (
    // Clock
    input  wire logic mclk,
    // Driven pins
    output var logic  timer0_event_pin,
    output var logic  timer1_event_pin,
    output var logic  ext_clock
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle levels at time zero
    initial begin
        timer0_event_pin = 1'b1;
        timer1_event_pin = 1'b1;
        ext_clock        = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Falling edges at mclk/4: two cycles low, two cycles high
    task automatic events(input int pin, input int n);
        repeat (n) begin
            repeat (2) @(posedge mclk);
            if (pin == 0) timer0_event_pin <= 1'b0;
            else timer1_event_pin <= 1'b0;
            repeat (2) @(posedge mclk);
            if (pin == 0) timer0_event_pin <= 1'b1;
            else timer1_event_pin <= 1'b1;
        end
    endtask : events

    // External clock burst, six mclk per period, 6*n edges of mclk
    task automatic ext_pulses(input int n);
        repeat (n) begin
            repeat (3) @(posedge mclk);
            ext_clock <= 1'b1;
            repeat (3) @(posedge mclk);
            ext_clock <= 1'b0;
        end
    endtask : ext_pulses
endmodule : qtc_pins
`default_nettype wire

// [testbench/qtc_top_bench.sv]
// Purpose: Self-checking bench for the quad timer/counter block
// Assumes: Counts sampled on the falling edge, inputs set on the rising
// Notes:   Rates are checked as count deltas over whole tick periods
`default_nettype none
module qtc_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import qtc_pkg::*;

    logic         mclk = 1'b0;
    logic         reset = 1'b1;
    logic [1:0]   divider = QTC_SCA_12;
    qtc_t01_ctl_s ctl0 = '0;
    qtc_t01_ctl_s ctl1 = '0;
    qtc_t23_ctl_s ctl2 = '0;
    qtc_t23_ctl_s ctl3 = '0;
    logic [7:0]   rl0 = 8'h00;
    logic [7:0]   rl1 = 8'h00;
    logic [15:0]  rl2 = 16'h0000;
    logic [15:0]  rl3 = 16'h0000;
    wire logic    ev0;
    wire logic    ev1;
    wire logic    extc;
    logic [15:0]  cnt0, cnt1, cnt2, cnt3;
    logic [15:0]  s0, s1, s2, s3;
    logic [7:0]   irq;
    int           irq_cnt [8];
    int           err_count = 0;
    int           checks_done = 0;
    int           dv [3] = '{12, 4, 48};

    // 20 MHz clock
    always #25 mclk = ~mclk;

    qtc_top dut_u (
        .mclk(mclk), .reset(reset), .timer01_divider_choice(divider),
        .timer0_ctl(ctl0), .timer1_ctl(ctl1),
        .timer2_control(ctl2), .timer3_control(ctl3),
        .timer0_reload(rl0), .timer1_reload(rl1),
        .timer2_reload(rl2), .timer3_reload(rl3),
        .timer0_event_pin(ev0), .timer1_event_pin(ev1), .ext_clock(extc),
        .timer0_count(cnt0), .timer1_count(cnt1),
        .timer2_count(cnt2), .timer3_count(cnt3), .overflow_irq(irq)
    );

    qtc_pins pins_u (
        .mclk(mclk), .timer0_event_pin(ev0), .timer1_event_pin(ev1),
        .ext_clock(extc)
    );

    // Tally of overflow pulses per bit
    always @(posedge mclk) begin
        for (int i = 0; i < 8; i++) begin
            if (irq[i] === 1'b1) irq_cnt[i]++;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Verdict and end of run
    task automatic stop_test();
        if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // Let n rising edges pass, then settle on the falling edge
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : step

    // Timer 0/1 control word
    function automatic qtc_t01_ctl_s c01(input logic r, cm, cc,
                                         input qtc_mode01_e m);
        return '{r, cm, cc, m};
    endfunction : c01

    // Short reset with all timers stopped
    task automatic do_reset();
        @(posedge mclk);
        reset   <= 1'b1;
        divider <= QTC_SCA_12;
        ctl0    <= '0;
        ctl1    <= '0;
        ctl2    <= '0;
        ctl3    <= '0;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        step(1);
        foreach (irq_cnt[i]) irq_cnt[i] = 0;
    endtask : do_reset

    // Snapshot of all counts
    task automatic snap();
        s0 = cnt0;
        s1 = cnt1;
        s2 = cnt2;
        s3 = cnt3;
    endtask : snap

    // Hang guard
    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        foreach (irq_cnt[i]) irq_cnt[i] = 0;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        step(1);
        // Reset values
        check("t0 rst", cnt0, QTC_CNT_RST);
        check("t1 rst", cnt1, QTC_CNT_RST);
        check("t2 rst", cnt2, QTC_CNT_RST);
        check("t3 rst", cnt3, QTC_CNT_RST);
        check("irq rst", {8'h00, irq}, 16'h0000);

        // Prescaled clock against system clock for the /12, /4 and /48 divider choices
        for (int i = 0; i < 3; i++) begin
            do_reset();
            @(posedge mclk);
            divider <= 2'(i);
            ctl0    <= c01(1'b1, 1'b0, 1'b0, QTC_M16);
            ctl1    <= c01(1'b1, 1'b0, 1'b1, QTC_M16);
            step(1);
            snap();
            step(96);
            check("t0 pre", cnt0 - s0, 16'(96 / dv[i]));
            check("t1 sys", cnt1 - s1, 16'd96);
        end

        // Event counting at mclk/4; clock choice ignored in counter mode
        do_reset();
        @(posedge mclk);
        ctl0 <= c01(1'b1, 1'b1, 1'b1, QTC_M16);
        ctl1 <= c01(1'b1, 1'b1, 1'b0, QTC_M16);
        step(1);
        snap();
        pins_u.events(0, 5);
        pins_u.events(1, 3);
        step(6);
        check("t0 events", cnt0 - s0, 16'd5);
        check("t1 events", cnt1 - s1, 16'd3);

        // 13-bit layout; timer 1 holds in split mode
        do_reset();
        @(posedge mclk);
        ctl0 <= c01(1'b1, 1'b0, 1'b1, QTC_M13);
        ctl1 <= c01(1'b1, 1'b0, 1'b1, QTC_MSPLIT);
        step(1);
        snap();
        step(40);
        check("t0 m13", 16'({cnt0[15:8], cnt0[4:0]}),
              16'({s0[15:8], s0[4:0]}) + 16'd40);
        check("t0 m13 gap", {13'h0, cnt0[7:5]}, 16'h0000);
        check("t1 hold", cnt1 - s1, 16'h0000);

        // Overflow pulses on every timer, reload periods on timers 1 to 3
        do_reset();
        @(posedge mclk);
        ctl0 <= c01(1'b1, 1'b0, 1'b1, QTC_M16);
        ctl1 <= c01(1'b1, 1'b0, 1'b1, QTC_M8AR);
        rl1  <= 8'hfc;
        rl2  <= 16'hffe0;
        rl3  <= 16'hfff0;
        ctl2 <= qtc_t23_ctl_s'(5'b10010); // Run, 16-bit, low on mclk
        ctl3 <= qtc_t23_ctl_s'(5'b10010); // Run, 16-bit, low on mclk
        step(65540);
        check("t0 wrap", 16'(irq_cnt[0]), 16'd1);
        foreach (irq_cnt[i]) irq_cnt[i] = 0;
        step(320);
        check("t1 ar8", 16'(irq_cnt[2]), 16'd80);
        check("t2 ar16", 16'(irq_cnt[4]), 16'd10);
        check("t3 ar16", 16'(irq_cnt[6]), 16'd20);
        check("t3 no hi", 16'(irq_cnt[7]), 16'd0);
        check("t2 no hi", 16'(irq_cnt[5]), 16'd0);
        check("irq3", 16'(irq_cnt[3]), 16'd0);

        // Timer 0 split; timers 2 and 3 split with per-half reload
        do_reset();
        @(posedge mclk);
        ctl0 <= c01(1'b1, 1'b0, 1'b1, QTC_MSPLIT);
        ctl1 <= c01(1'b1, 1'b0, 1'b0, QTC_M13);
        ctl2 <= qtc_t23_ctl_s'(5'b11011); // Run, split, both on mclk
        ctl3 <= qtc_t23_ctl_s'(5'b11011); // Run, split, both on mclk
        rl2  <= 16'hf0e0;
        rl3  <= 16'he0f0;
        step(520);
        check("t0 split lo", 16'(irq_cnt[0]), 16'd2);
        check("t0 split hi", 16'(irq_cnt[1]), 16'd2);
        check("t2 split lo", 16'(irq_cnt[4]), 16'd9);
        check("t2 split hi", 16'(irq_cnt[5]), 16'd17);
        check("t3 split lo", 16'(irq_cnt[6]), 16'd17);
        check("t3 split hi", 16'(irq_cnt[7]), 16'd9);

        // Timer 0 8-bit reload, high byte untouched
        do_reset();
        @(posedge mclk);
        ctl0 <= c01(1'b1, 1'b0, 1'b1, QTC_M8AR);
        rl0  <= 8'hf8;
        step(320);
        check("t0 ar8", 16'(irq_cnt[0]), 16'd8);
        check("t0 ar8 hi", {8'h00, cnt0[15:8]}, 16'h0000);

        // External clock /8 for timers 0 and 3, mclk/12 for timer 2
        do_reset();
        @(posedge mclk);
        divider <= QTC_SCA_EXT;
        ctl0    <= c01(1'b1, 1'b0, 1'b0, QTC_M16);
        ctl2    <= qtc_t23_ctl_s'(5'b10000); // Run, alt clock mclk/12
        ctl3    <= qtc_t23_ctl_s'(5'b10100); // Run, alt clock ext/8
        step(1);
        snap();
        pins_u.ext_pulses(40);
        step(12);
        check("t0 ext", cnt0 - s0, 16'd5);
        check("t2 div12", cnt2 - s2, 16'd21);
        check("t3 ext", cnt3 - s3, 16'd5);
        stop_test();
    end
endmodule : qtc_top_bench
`default_nettype wire
